/* mtg_pkg.sv */
// Constants, register map, states and carrier types of the motor lock and fault guard.
// Assumes one 10 MHz clock. Currents are in mA, voltages and speeds in raw sensor units.
package mtg_pkg;
  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000;     // Core clock rate
  localparam int LOCK_OFF_MS   = 1000;           // Wait in high impedance before retry
  localparam int LOCK_OFF_CYC  = LOCK_OFF_MS * (CLK_HZ / 1000);
  localparam int LCK_ETR_MS    = 100;            // Out-of-window time before lock
  localparam int LCK_ETR_CYC   = LCK_ETR_MS * (CLK_HZ / 1000);
  localparam int BRK_UNIT_US   = 10;             // Brake exit time step
  localparam int BRK_UNIT_CYC  = (BRK_UNIT_US * CLK_HZ + 999_999) / 1_000_000;
  // ------------------------------------------------------------------
  // Current scales
  // ------------------------------------------------------------------
  localparam logic [11:0] NO_MOTOR_MA  = 12'h08C;  // 140 mA floor after hand-off
  localparam logic [11:0] ACC_STEP_MA  = 12'h0C8;  // Accel ceiling step
  localparam logic [11:0] TRIP_STEP_MA = 12'h1F4;  // Lock trip step
  localparam logic [11:0] BRK_STEP_MA  = 12'h032;  // Brake exit current step
  localparam int          KT_SCALE     = 4;        // Measured constant vs programmed
  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LIMIT  = 8'h04;
  localparam logic [7:0] OFS_MOTOR  = 8'h08;
  localparam logic [7:0] OFS_DETEN  = 8'h0C;
  localparam logic [7:0] OFS_SPDWIN = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_VOLT   = 8'h18;
  localparam logic [7:0] OFS_KTC    = 8'h1C;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_RUN  = 0;   // Motor run request
  localparam int CTRL_MECH = 1;   // Mechanical surge guard enable
  localparam int CTRL_IND  = 2;   // Inductive surge guard enable
  localparam int LIM_ACC   = 0;   // Accel ceiling select [3:0]
  localparam int LIM_TRIP  = 4;   // Lock trip select [2:0]
  localparam int LIM_WIN   = 8;   // Constant window select [1:0]
  localparam int LIM_BCUR  = 12;  // Brake exit current select [2:0]
  localparam int LIM_BTIM  = 16;  // Brake exit time select [2:0]
  localparam int MOT_R     = 0;   // Phase resistance [7:0]
  localparam int MOT_KT    = 8;   // Programmed constant [6:0]
  localparam int ST_OC     = 8;   // Overcurrent flag in status
  localparam int ST_STATE  = 12;  // State code in status
  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] CTRL_RST   = 32'h0000_0006;
  localparam logic [31:0] LIMIT_RST  = 32'h0003_1177;
  localparam logic [31:0] MOTOR_RST  = 32'h0000_2010;
  localparam logic [31:0] DETEN_RST  = 32'h0000_003F;
  localparam logic [31:0] SPDWIN_RST = 32'hFFFF_0000;
  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,   // Outputs off, not running
    ST_DRIVE = 4'b0010,   // Driving the motor
    ST_BRAKE = 4'b0100,   // Low sides on, waiting for current decay
    ST_LKOFF = 4'b1000    // High impedance after a fault
  } mtg_state_t;

  typedef struct packed {
    logic        closed_loop;   // Commutation runs in closed loop
    logic        ol_handoff;    // Open-loop drive rate past hand-off threshold
    logic        ol_to_cl;      // Pulse: open to closed loop transition
    logic        bemf_seen;     // Pulse: BEMF zero cross detected
    logic        elec_cycle;    // Pulse: one electrical cycle of drive elapsed
    logic        half_cycle;    // Pulse: half electrical cycle boundary
    logic        comm_edge;     // Pulse: commutation step
    logic        oc_trip;       // Fixed-threshold overcurrent comparator
    logic [7:0]  bemf_sample;   // BEMF magnitude, one sample per clock
    logic [15:0] speed;         // Estimated electrical speed
    logic [11:0] ls_current;    // Low-side driver current, mA
    logic [11:0] u_current;     // Phase U current, mA
    logic [11:0] ph_current;    // Phase current amplitude, mA
    logic [23:0] u_cmd;         // Requested voltage amplitude
  } mtg_sense_t;

  typedef struct packed {
    logic        drive_en;      // Bridge follows commutation
    logic        hs_off;        // All high sides forced off
    logic        ls_on;         // All low sides forced on (brake)
    logic        hiz;           // All outputs high impedance
    logic        restart;       // Pulse: start motor sequence anew
    logic [23:0] u_applied;     // Voltage amplitude after limiting
  } mtg_drive_t;
endpackage

/* mtg_guard.sv */
// Lock detection, fault reaction, surge hand-off and accel limit of the motor driver.
// Assumes an AHB-Lite master on the register side and a commutation core that
// supplies synchronous sense pulses and consumes the drive controls.
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

// Operation
// - Overcurrent always on, fixed, not configurable
// - Accel limit only cuts voltage, no fault
// - Ceiling times resistance plus speed times constant
// - Accel limit closed loop only, never stops
// - Six enable bits gate detector reactions
// - Flags set even when detector disabled
// - All six flags clear on restart
// - Fault gives high impedance via surge hand-off
// - Retry after lock-off time
// - Low-side current trip sets flag, retries
// - Integrate BEMF over half cycle continuously
// - Constant outside window too long is lock
// - No phase U current after hand-off faults
// - No BEMF one cycle past hand-off
// - Commutation period over twice previous locks
// - Separate mechanical and inductive guard enables
// - Brake low sides until current stays low
// - Zero brake time skips brake phase
module mtg_guard #(
  parameter int LOCK_OFF_CYC   = mtg_pkg::LOCK_OFF_CYC,  // Lock-off wait
  parameter int LOCK_ENTRY_CYC = mtg_pkg::LCK_ETR_CYC    // Window dwell time
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire mtg_pkg::mtg_sense_t sense,
  output mtg_pkg::mtg_drive_t     drive
);
  // ------------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------------
  logic [31:0] ctrl_reg, limit_reg, motor_reg, deten_reg, spdwin_reg;
  logic [31:0] hrdata_reg;       // Read data, loaded in address phase
  logic [7:0]  waddr_reg;        // Write address held for data phase
  logic        wpend_reg;        // Write data phase pending
  wire         acc_ok = hsel & htrans[1] & hready;  // Valid address phase
  wire         wr_now = wpend_reg;

  assign hreadyout = 1'b1;       // Zero wait states
  assign hresp     = 1'b0;       // Always OKAY
  assign hrdata    = hrdata_reg;
  wire _unused = &{1'b0, hsize, haddr[31:8], haddr[1:0]};

  // Write phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_reg <= 1'b0;
      waddr_reg <= 8'h00;
    end else begin
      wpend_reg <= acc_ok & hwrite;
      waddr_reg <= {haddr[7:2], 2'b00};
    end
  end

  // Configuration registers, written in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg   <= mtg_pkg::CTRL_RST;
      limit_reg  <= mtg_pkg::LIMIT_RST;
      motor_reg  <= mtg_pkg::MOTOR_RST;
      deten_reg  <= mtg_pkg::DETEN_RST;
      spdwin_reg <= mtg_pkg::SPDWIN_RST;
    end else if (wr_now) begin
      // Reserved bits are dropped on write so they read as zero
      if (waddr_reg == mtg_pkg::OFS_CTRL)   ctrl_reg   <= hwdata & 32'h0000_0007;
      if (waddr_reg == mtg_pkg::OFS_LIMIT)  limit_reg  <= hwdata & 32'h0007_737F;
      if (waddr_reg == mtg_pkg::OFS_MOTOR)  motor_reg  <= hwdata & 32'h0000_7FFF;
      if (waddr_reg == mtg_pkg::OFS_DETEN)  deten_reg  <= hwdata & 32'h0000_003F;
      if (waddr_reg == mtg_pkg::OFS_SPDWIN) spdwin_reg <= hwdata;
    end
  end

  // ------------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------------
  wire        run_en   = ctrl_reg[mtg_pkg::CTRL_RUN];
  wire        mech_en  = ctrl_reg[mtg_pkg::CTRL_MECH];
  wire        ind_en   = ctrl_reg[mtg_pkg::CTRL_IND];
  wire [3:0]  acc_sel  = limit_reg[mtg_pkg::LIM_ACC +: 4];
  wire [2:0]  trip_sel = limit_reg[mtg_pkg::LIM_TRIP +: 3];
  wire [1:0]  win_sel  = limit_reg[mtg_pkg::LIM_WIN +: 2];
  wire [2:0]  bcur_sel = limit_reg[mtg_pkg::LIM_BCUR +: 3];
  wire [2:0]  btim_sel = limit_reg[mtg_pkg::LIM_BTIM +: 3];
  wire [7:0]  r_ph     = motor_reg[mtg_pkg::MOT_R +: 8];
  wire [6:0]  programmed_bemf_const    = motor_reg[mtg_pkg::MOT_KT +: 7];
  wire [5:0]  det_mask = deten_reg[5:0];
  wire [15:0] spd_min  = spdwin_reg[15:0];
  wire [15:0] spd_max  = spdwin_reg[31:16];

  // Step threshold: (sel + 1) * step, shared by all current selects
  function automatic logic [11:0] step_thr(input logic [3:0] sel,
                                           input logic [11:0] step);
    logic [15:0] p;
    p = ({12'h000, sel} + 16'h0001) * {4'h0, step};
    // Saturate rather than wrap if a large select overflows the mA scale
    return (p > 16'h0FFF) ? 12'hFFF : p[11:0];
  endfunction

  wire [11:0] acc_ma  = step_thr(acc_sel, mtg_pkg::ACC_STEP_MA);
  wire [11:0] trip_ma = step_thr({1'b0, trip_sel}, mtg_pkg::TRIP_STEP_MA);
  wire [11:0] bcur_ma = step_thr({1'b0, bcur_sel}, mtg_pkg::BRK_STEP_MA);

  // ------------------------------------------------------------------
  // Voltage limiting
  // ------------------------------------------------------------------
  wire [23:0] bemf_v  = 24'(sense.speed) * 24'(programmed_bemf_const);
  wire [23:0] u_limit = 24'(acc_ma) * 24'(r_ph) + bemf_v;
  wire        clamp   = sense.closed_loop & (sense.u_cmd > u_limit);
  wire [23:0] u_acc   = clamp ? u_limit : sense.u_cmd;
  wire        floor_v = mech_en & (u_acc < bemf_v);
  wire [23:0] u_next  = floor_v ? bemf_v : u_acc;
  logic [23:0] u_reg;

  // Applied amplitude; the limiter feeds no flag at all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) u_reg <= 24'h000000;
    else          u_reg <= u_next;
  end

  // ------------------------------------------------------------------
  // Detectors
  // ------------------------------------------------------------------
  mtg_pkg::mtg_state_t st_reg, st_next;
  wire in_drive = (st_reg == mtg_pkg::ST_DRIVE);

  // Measured constant: BEMF summed over each half cycle
  logic [15:0] acc_reg, ktc_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= 16'h0000;
      ktc_reg <= 16'h0000;
    end else if (sense.half_cycle) begin
      ktc_reg <= acc_reg;
      acc_reg <= 16'(sense.bemf_sample);
    end else begin
      acc_reg <= acc_reg + 16'(sense.bemf_sample);
    end
  end

  // Window around the programmed constant, narrower for larger selects
  wire [15:0] kt_ref  = 16'(programmed_bemf_const) << mtg_pkg::KT_SCALE;
  wire [15:0] kt_span = kt_ref >> (3'd1 + {1'b0, win_sel});
  wire        kt_out  = (ktc_reg < kt_ref - kt_span) | (ktc_reg > kt_ref + kt_span);
  logic [23:0] kt_cnt_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                   kt_cnt_reg <= 24'h000000;
    else if (!kt_out || !in_drive)  kt_cnt_reg <= 24'h000000;
    else if (kt_cnt_reg != 24'hFFFFFF) kt_cnt_reg <= kt_cnt_reg + 24'h000001;
  end
  wire d_kt = kt_cnt_reg >= 24'(LOCK_ENTRY_CYC);

  // Open-loop stuck: armed at hand-off, any BEMF disarms
  logic ol_arm_reg, ol_seen_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ol_arm_reg  <= 1'b0;
      ol_seen_reg <= 1'b0;
    end else begin
      ol_arm_reg  <= in_drive & ~sense.closed_loop & sense.ol_handoff;
      ol_seen_reg <= (ol_arm_reg & ~sense.elec_cycle) &
                     (ol_seen_reg | sense.bemf_seen);
    end
  end
  wire d_ol = ol_arm_reg & sense.elec_cycle & ~ol_seen_reg & ~sense.bemf_seen;

  // Closed-loop stuck: running period against previous period
  logic [23:0] per_cnt_reg, per_prev_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt_reg  <= 24'h000000;
      per_prev_reg <= 24'h000000;
    end else if (sense.comm_edge || !in_drive) begin
      per_cnt_reg  <= 24'h000001;
      per_prev_reg <= in_drive ? per_cnt_reg : 24'h000000;
    end else if (per_cnt_reg != 24'hFFFFFF) begin
      per_cnt_reg  <= per_cnt_reg + 24'h000001;
    end
  end
  wire [24:0] per_twice = {per_prev_reg, 1'b0};
  wire d_cl = sense.closed_loop & (per_prev_reg != 24'h000000) &
              ({1'b0, per_cnt_reg} > per_twice);

  // Detector vector, bit order matches the status flags
  wire [5:0] det_hit;
  assign det_hit[0] = in_drive & (sense.ls_current > trip_ma);
  assign det_hit[1] = in_drive & sense.closed_loop &
                      ((sense.speed < spd_min) | (sense.speed > spd_max));
  assign det_hit[2] = d_kt;
  assign det_hit[3] = in_drive & sense.ol_to_cl &
                      (sense.u_current <= mtg_pkg::NO_MOTOR_MA);
  assign det_hit[4] = in_drive & d_ol;
  assign det_hit[5] = in_drive & d_cl;

  // ------------------------------------------------------------------
  // Fault flags
  // ------------------------------------------------------------------
  logic [5:0] flag_reg;       // fault_status_word
  logic       oc_flag_reg;    // Overcurrent seen
  logic       restart_reg;    // One-cycle restart pulse
  wire        oc_hit = in_drive & sense.oc_trip;
  wire        fault  = |(det_hit & det_mask) | oc_hit;

  // Sticky; a hit in the restart cycle still lands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg    <= 6'h00;
      oc_flag_reg <= 1'b0;
    end else begin
      flag_reg    <= (restart_reg ? 6'h00 : flag_reg) | det_hit;
      oc_flag_reg <= (oc_flag_reg & ~restart_reg) | oc_hit;
    end
  end

  // ------------------------------------------------------------------
  // Fault and hand-off sequencer
  // ------------------------------------------------------------------
  logic [23:0] tmr_reg;       // Brake dwell or lock-off count
  logic        lock_reg;      // High impedance was caused by a fault
  wire  [11:0] brk_cyc  = 12'(btim_sel * mtg_pkg::BRK_UNIT_CYC);
  wire         brk_use  = ind_en & (btim_sel != 3'b000);
  wire         cur_low  = sense.ph_current < bcur_ma;
  wire         brk_done = cur_low & (tmr_reg >= 24'(brk_cyc) - 24'h1);
  wire         lk_done  = tmr_reg >= 24'(LOCK_OFF_CYC - 1);
  wire         leave    = fault | ~run_en;

  // Next state
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      mtg_pkg::ST_IDLE:  if (run_en) st_next = mtg_pkg::ST_DRIVE;
      mtg_pkg::ST_DRIVE: if (leave) begin
        if (brk_use)     st_next = mtg_pkg::ST_BRAKE;
        else if (fault)  st_next = mtg_pkg::ST_LKOFF;
        else             st_next = mtg_pkg::ST_IDLE;
      end
      mtg_pkg::ST_BRAKE: if (brk_done)
        st_next = lock_reg ? mtg_pkg::ST_LKOFF : mtg_pkg::ST_IDLE;
      mtg_pkg::ST_LKOFF: if (!run_en) st_next = mtg_pkg::ST_IDLE;
        else if (lk_done) st_next = mtg_pkg::ST_DRIVE;
      default:           st_next = mtg_pkg::ST_IDLE;
    endcase
  end

  // State, timers and restart pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg      <= mtg_pkg::ST_IDLE;
      tmr_reg     <= 24'h000000;
      lock_reg    <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      st_reg      <= st_next;
      restart_reg <= (st_next == mtg_pkg::ST_DRIVE) & ~in_drive;
      if (in_drive) lock_reg <= fault;
      // Brake dwell restarts whenever current rises again
      if (st_next != st_reg || (st_reg == mtg_pkg::ST_BRAKE && !cur_low))
        tmr_reg <= 24'h000000;
      else if (tmr_reg != 24'hFFFFFF)
        tmr_reg <= tmr_reg + 24'h000001;
    end
  end

  // ------------------------------------------------------------------
  // Bridge controls
  // ------------------------------------------------------------------
  assign drive.drive_en  = in_drive;
  assign drive.hs_off    = ~in_drive;
  assign drive.ls_on     = st_reg == mtg_pkg::ST_BRAKE;
  assign drive.hiz       = st_reg[0] | st_reg[3];
  assign drive.restart   = restart_reg;
  assign drive.u_applied = u_reg;

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  wire [31:0] status_w = {16'h0000, 4'(st_reg), 3'b000, oc_flag_reg, 2'b00, flag_reg};
  wire [7:0]  raddr    = {haddr[7:2], 2'b00};
  logic [31:0] rmux;
  always_comb begin
    unique case (raddr)
      mtg_pkg::OFS_CTRL:   rmux = ctrl_reg;
      mtg_pkg::OFS_LIMIT:  rmux = limit_reg;
      mtg_pkg::OFS_MOTOR:  rmux = motor_reg;
      mtg_pkg::OFS_DETEN:  rmux = deten_reg;
      mtg_pkg::OFS_SPDWIN: rmux = spdwin_reg;
      mtg_pkg::OFS_STATUS: rmux = status_w;
      mtg_pkg::OFS_VOLT:   rmux = {8'h00, u_reg};
      mtg_pkg::OFS_KTC:    rmux = {16'h0000, ktc_reg};
      default:             rmux = 32'h0000_0000;   // Unmapped reads zero
    endcase
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                hrdata_reg <= 32'h0000_0000;
    else if (acc_ok && !hwrite)  hrdata_reg <= rmux;
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_oc_leaves_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    in_drive && sense.oc_trip |=> !drive.drive_en)
    else $error("overcurrent did not stop drive");
  a_skip_brake: assert property (@(posedge hclk) disable iff (!hresetn)
    in_drive && fault && btim_sel == 3'b000 |=> drive.hiz && !drive.ls_on)
    else $error("brake not skipped");
  a_brake_first: assert property (@(posedge hclk) disable iff (!hresetn)
    in_drive && fault && brk_use |=> drive.ls_on && drive.hs_off && !drive.hiz)
    else $error("hand-off did not brake");
  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    det_hit[0] || (flag_reg[0] && !restart_reg) |=> flag_reg[0])
    else $error("flag lost");
  a_restart_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    restart_reg && det_hit == 6'h00 |=> flag_reg == 6'h00)
    else $error("restart left flags");
  a_accel_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
    clamp && !mech_en |=> drive.u_applied == $past(u_limit))
    else $error("accel clamp wrong");
  a_open_loop_free: assert property (@(posedge hclk) disable iff (!hresetn)
    !sense.closed_loop && !mech_en |=> drive.u_applied == $past(sense.u_cmd))
    else $error("open loop limited");
  a_no_motor: assert property (@(posedge hclk) disable iff (!hresetn)
    in_drive && sense.ol_to_cl && sense.u_current <= 12'h08C |=> flag_reg[3])
    else $error("no-motor missed");
  a_lockoff_retry: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg == mtg_pkg::ST_LKOFF && run_en && lk_done |=> in_drive ##0 restart_reg)
    else $error("no retry");
endmodule // mtg_guard

/* mtg_motor.sv */
// Behavioural windings and current sense on the far side of the guard.
// Assumes the guard's drive controls; the bench commands jams and shorts.
`timescale 1ns/1ps
module mtg_motor (
  input  wire logic                hclk,
  input  wire logic                jam,     // Low-side overload request
  input  wire logic                short,   // Fixed comparator trip request
  input  wire logic                cl,      // Closed loop commutation request
  input  wire mtg_pkg::mtg_drive_t drive,
  output mtg_pkg::mtg_sense_t      sense
);
  logic [3:0]  pos_reg = 4'h0;   // Position in half cycle
  logic [11:0] cur_reg = 12'h000; // Winding current, mA
  // Current holds while driven, decays slowly when braked or open
  always_ff @(posedge hclk) begin
    pos_reg <= pos_reg + 4'h1;
    cur_reg <= drive.drive_en ? 12'h3E8 : (cur_reg > 12'h010 ? cur_reg - 12'h010 : 12'h000);
  end
  // Steady BEMF keeps the measured constant inside its window
  always_comb begin
    sense             = '0;
    sense.half_cycle  = (pos_reg == 4'hF);
    sense.closed_loop = cl;
    sense.u_cmd       = 24'h00FFFF;   // Demand well above the accel ceiling
    sense.bemf_sample = 8'h20;
    sense.ph_current  = cur_reg;
    sense.u_current   = cur_reg;
    sense.oc_trip     = short;
    sense.ls_current  = jam ? 12'hFA1 : cur_reg;
  end
endmodule // mtg_motor

/* motor_lock_fault_guard_test.sv */
// Self-checking bench of the motor lock and fault guard.
// Assumes one AHB-Lite slave and the behavioural motor on the sense side.
`timescale 1ns/1ps
`define CK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module motor_lock_fault_guard_test;
  localparam int LOFF = 50;   // Shortened lock-off wait
  logic                hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic                jam = 1'b0, short = 1'b0, cl = 1'b0, hreadyout, hresp;
  logic [31:0]         haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]          htrans = 2'b00;
  mtg_pkg::mtg_sense_t sense;
  mtg_pkg::mtg_drive_t drive;
  int                  n_mismatch = 0, comparisons = 0, cyc = 0, k;
  mtg_guard #(.LOCK_OFF_CYC(LOFF), .LOCK_ENTRY_CYC(20)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sense(sense), .drive(drive));
  mtg_motor motor (.hclk(hclk), .jam(jam), .short(short), .cl(cl), .drive(drive),
    .sense(sense));
  initial forever #50 hclk = ~hclk;
  // Cut a hang short
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // One single-word transfer, waiting on ready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // Wait for ls_on (0), hiz (1) or restart (2), counting cycles in k
  task automatic wait_on(input int s);
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (!(s == 0 ? drive.ls_on : s == 1 ? drive.hiz : drive.restart) && k < 1000);
  endtask
  // Reset values, start, low-side trip through brake and retry
  task automatic s_trip;
    bus(0, mtg_pkg::OFS_LIMIT, 0); `CK(q, mtg_pkg::LIMIT_RST)
    bus(0, mtg_pkg::OFS_DETEN, 0); `CK(q, mtg_pkg::DETEN_RST)
    bus(1, mtg_pkg::OFS_CTRL, 32'h0000_0007);
    wait_on(2); `CK(drive.drive_en, 1'b1)
    jam <= 1'b1;
    wait_on(0); `CK(drive.hs_off, 1'b1)
    jam <= 1'b0;
    bus(0, mtg_pkg::OFS_STATUS, 0); `CK(q[15:0], 16'h4001)
    wait_on(1); `CK(k > 200, 1'b1)
    wait_on(2); `CK(k >= LOFF - 3 && k <= LOFF + 3, 1'b1)
    bus(0, mtg_pkg::OFS_STATUS, 0); `CK(q[5:0], 6'h00)
    $display("test trip done");
  endtask
  // Zero brake time and fixed overcurrent go straight to high impedance
  task automatic s_short;
    bus(1, mtg_pkg::OFS_LIMIT, mtg_pkg::LIMIT_RST & 32'hFFF8_FFFF); // zero brake time
    short <= 1'b1;
    @(posedge hclk);
    @(posedge hclk);
    `CK({drive.hiz, drive.ls_on}, 2'b10)
    short <= 1'b0;
    bus(0, mtg_pkg::OFS_STATUS, 0); `CK(q[8], 1'b1)
    wait_on(2); `CK(drive.drive_en, 1'b1)
    $display("test short done");
  endtask
  // Masked detector still flags but does not react
  task automatic s_mask;
    bus(1, mtg_pkg::OFS_DETEN, 32'h0000_003E);
    jam <= 1'b1;
    bus(0, mtg_pkg::OFS_STATUS, 0); `CK(q[0], 1'b1)
    `CK(drive.drive_en, 1'b1)
    jam <= 1'b0;
    $display("test mask done");
  endtask
  // Accel ceiling clamps in closed loop only; mechanical floor off
  task automatic s_accel;
    bus(1, mtg_pkg::OFS_CTRL, 32'h0000_0005);
    cl <= 1'b1;
    repeat (3) @(posedge hclk);
    `CK(drive.u_applied, 24'(8 * mtg_pkg::ACC_STEP_MA * 16))
    `CK(drive.drive_en, 1'b1)
    bus(0, mtg_pkg::OFS_STATUS, 0); `CK({q[8], q[5:1]}, 6'h00)
    cl <= 1'b0;
    repeat (3) @(posedge hclk);
    `CK(drive.u_applied, 24'h00FFFF)
    $display("test accel done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    s_trip();
    s_short();
    s_mask();
    s_accel();
    test_done();
  end
endmodule // motor_lock_fault_guard_test
